/* include/adc_cmd_pkg.sv */
// Constants, encodings and carrier types for the converter serial command decoder
package adc_cmd_pkg;

	// Register map
	localparam int         REG_COUNT          = 15;
	localparam logic [3:0] OFS_INPUT_SELECT   = 4'h0;
	localparam logic [3:0] OFS_BIAS_VOLTAGE   = 4'h1;
	localparam logic [3:0] OFS_REF_CLK_CAL    = 4'h2;
	localparam logic [3:0] OFS_GAIN_RATE      = 4'h3;
	localparam logic [3:0] OFS_OFFSET_LOW     = 4'h4;
	localparam logic [3:0] OFS_OFFSET_MID     = 4'h5;
	localparam logic [3:0] OFS_OFFSET_HIGH    = 4'h6;
	localparam logic [3:0] OFS_GAIN_LOW       = 4'h7;
	localparam logic [3:0] OFS_GAIN_MID       = 4'h8;
	localparam logic [3:0] OFS_GAIN_HIGH      = 4'h9;
	localparam logic [3:0] OFS_EXC_MAGNITUDE  = 4'hA;
	localparam logic [3:0] OFS_EXC_ROUTING    = 4'hB;
	localparam logic [3:0] OFS_GPIO_CONFIG    = 4'hC;
	localparam logic [3:0] OFS_GPIO_DIRECTION = 4'hD;
	localparam logic [3:0] OFS_GPIO_VALUE     = 4'hE;

	// Reset values, entry 14 first down to entry 0
	localparam logic [REG_COUNT-1:0][7:0] REG_RESET = {
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01
	};

	// Read-only fields and the reference control field position
	localparam logic [7:0] CLKSTAT_MASK   = 8'h80;
	localparam int         CLKSTAT_BIT    = 7;
	localparam logic [7:0] ID_MASK        = 8'hF0;
	localparam int         REF_CTRL_LSB   = 5;

	// Command codes; seven-bit ones ignore the lowest bit
	localparam logic [6:0] CMD_EXIT_PD    = 7'h00;
	localparam logic [6:0] CMD_ENTER_PD   = 7'h01;
	localparam logic [6:0] CMD_RESTART    = 7'h02;
	localparam logic [6:0] CMD_RESET      = 7'h03;
	localparam logic [6:0] CMD_READ_ONCE  = 7'h09;
	localparam logic [6:0] CMD_CONT_READ  = 7'h0A;
	localparam logic [6:0] CMD_STOP_CONT  = 7'h0B;
	localparam logic [3:0] CMD_REG_READ   = 4'h2;
	localparam logic [3:0] CMD_REG_WRITE  = 4'h4;
	localparam logic [7:0] CMD_SYS_OFFSET = 8'h60;
	localparam logic [7:0] CMD_SYS_GAIN   = 8'h61;
	localparam logic [7:0] CMD_INT_OFFSET = 8'h62;
	localparam logic [7:0] CMD_NO_OP      = 8'hFF;

	// Timing
	localparam int MCLK_PERIOD_NS    = 40;
	localparam int RESET_HOLD_NS     = 600000;
	localparam int RESET_HOLD_CYCLES = (RESET_HOLD_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

	// Readout
	localparam int         OUT_BYTES    = 16;
	localparam logic [4:0] RESULT_BYTES = 5'h02;

	typedef enum logic [3:0] {
		ST_IDLE     = 4'b0001,
		ST_RD_COUNT = 4'b0010,
		ST_WR_COUNT = 4'b0100,
		ST_WR_DATA  = 4'b1000
	} cmd_state_e;

	typedef enum logic [1:0] {
		CAL_SYS_OFFSET = 2'h0,
		CAL_SYS_GAIN   = 2'h1,
		CAL_INT_OFFSET = 2'h2
	} cal_kind_e;

	typedef struct packed {
		logic        valid;
		logic [15:0] code;
	} conv_in_s;

	typedef struct packed {
		logic        done;
		logic [23:0] value;
	} cal_in_s;

	typedef struct packed {
		logic      start;
		cal_kind_e kind;
	} cal_req_s;

endpackage

/* verilog/adc_serial_command_decoder.sv */
// Serial command decoder and configuration register file of the converter
`timescale 1ns/1ps

module adc_serial_command_decoder #(
	parameter int         RESET_HOLD = adc_cmd_pkg::RESET_HOLD_CYCLES, // Reset hold in mclk cycles
	parameter logic [3:0] DEVICE_ID  = 4'h5                            // Arbitrary identity value
) (
	input  wire logic                                      mclk,           // System clock
	input  wire logic                                      sys_rst,        // Sync reset, high
	input  wire logic                                      serial_clk,     // Host serial clock
	input  wire logic                                      cs_n,           // Chip select, low
	input  wire logic                                      serial_in,      // Host to device data
	output logic                                           serial_out,     // Device to host data
	input  wire logic                                      start_pin,      // Start pin, async
	input  wire logic                                      clk_stat,       // Oscillator status
	input  wire adc_cmd_pkg::conv_in_s                     conv_in,        // Finished conversion
	input  wire adc_cmd_pkg::cal_in_s                      cal_in,         // Finished calibration
	output logic                                           result_ready_n, // Result ready, low
	output logic                                           power_down,     // Power-down state
	output logic                                           filter_clear,   // Clear decimator
	output logic                                           conv_restart,   // Start conversion pulse
	output adc_cmd_pkg::cal_req_s                          cal_req,        // Calibration request
	output logic [1:0]                                     ref_power_ctrl, // Reference control
	output logic [adc_cmd_pkg::REG_COUNT-1:0][7:0]         cfg_regs        // Register file
);

	localparam int HOLD_W = $clog2(RESET_HOLD + 1);

	// Link domain
	logic [2:0]  link_bit;
	logic [6:0]  link_shift;
	logic        rx_tgl;
	logic [7:0]  link_byte;
	logic [7:0]  rx_hold [2];
	wire  [7:0]  rx_byte_now = {link_shift, serial_in};
	wire         byte_done   = (link_bit == 3'h7);

	// Words handed to the link side; held still by the readout timing contract
	logic [adc_cmd_pkg::OUT_BYTES-1:0][7:0] out_buf;
	logic [7:0]  out_start;
	logic [4:0]  out_len;

	wire  [7:0]  tx_rel = link_byte - out_start;
	wire         tx_hit = tx_rel < {3'h0, out_len};
	wire  [7:0]  tx_byte = out_buf[tx_rel[3:0]];
	wire         tx_bit  = tx_hit ? tx_byte[3'h7 - link_bit] : 1'b1;

	// Raised chip select frames the link: counters restart, byte alignment recovers
	always_ff @(posedge serial_clk or posedge cs_n) begin
		if (cs_n) begin
			link_bit   <= 3'h0;
			link_shift <= 7'h00;
			rx_tgl     <= 1'b0;
			link_byte  <= 8'h00;
		end else begin
			link_bit   <= link_bit + 3'h1;
			link_shift <= rx_byte_now[6:0];
			if (byte_done) begin
				rx_tgl    <= ~rx_tgl;
				link_byte <= link_byte + 8'h01;
			end
		end
	end

	// Two alternating holding slots give the slower clock two byte times to read each
	always_ff @(posedge serial_clk) begin
		if (!cs_n && byte_done) begin
			rx_hold[rx_tgl] <= rx_byte_now;
		end
	end

	// Data leave on the rising edge, MSB first; idle bits read as ones
	always_ff @(posedge serial_clk or posedge cs_n) begin
		if (cs_n) begin
			serial_out <= 1'b1;
		end else begin
			serial_out <= tx_bit;
		end
	end

	// System domain
	logic [1:0]  cs_sync;
	logic [1:0]  rx_sync;
	logic [1:0]  start_sync;
	logic        rx_seen;
	logic [7:0]  rx_idx;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cs_sync    <= 2'b11;
			rx_sync    <= 2'b00;
			start_sync <= 2'b00;
		end else begin
			cs_sync    <= {cs_sync[0], cs_n};
			rx_sync    <= {rx_sync[0], rx_tgl};
			start_sync <= {start_sync[0], start_pin};
		end
	end

	wire        cs_high  = cs_sync[1];
	wire        start_hi = start_sync[1];
	wire        rx_event = (rx_sync[1] != rx_seen) && !cs_high;
	wire  [7:0] byte_in  = rx_hold[rx_seen];

	// Follow the toggle while deselected so its reset to zero is not taken as a byte
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			rx_seen <= 1'b0;
			rx_idx  <= 8'h00;
		end else if (cs_high) begin
			rx_seen <= rx_sync[1];
			rx_idx  <= 8'h00;
		end else if (rx_event) begin
			rx_seen <= ~rx_seen;
			rx_idx  <= rx_idx + 8'h01;
		end
	end

	adc_cmd_pkg::cmd_state_e state;
	logic [3:0]        addr_q;
	logic [3:0]        wr_left;
	logic              out_is_reg;
	logic [HOLD_W-1:0] hold_cnt;
	logic [15:0]       latest;
	logic              ready_fall;
	logic              sleep_pend;
	logic              cont_mode;
	logic              mode_pend;
	logic              mode_next;

	function automatic logic [3:0] next_addr(input logic [3:0] a);
		return (a >= 4'(adc_cmd_pkg::REG_COUNT - 1)) ? 4'h0 : a + 4'h1;
	endfunction

	function automatic logic [7:0] ro_mask(input logic [3:0] a);
		if (a == adc_cmd_pkg::OFS_REF_CLK_CAL)
			return adc_cmd_pkg::CLKSTAT_MASK;
		if (a == adc_cmd_pkg::OFS_EXC_MAGNITUDE)
			return adc_cmd_pkg::ID_MASK;
		return 8'h00;
	endfunction

	function automatic logic [7:0] rd_reg(input logic [3:0] a);
		logic [7:0] v;
		v = (a < 4'(adc_cmd_pkg::REG_COUNT)) ? cfg_regs[a] : 8'h00;
		if (a == adc_cmd_pkg::OFS_REF_CLK_CAL)
			v[adc_cmd_pkg::CLKSTAT_BIT] = clk_stat;
		if (a == adc_cmd_pkg::OFS_EXC_MAGNITUDE)
			v = {DEVICE_ID, v[3:0]};
		return v;
	endfunction

	// Decode of the byte now being taken
	wire  [7:0] rel_idx     = rx_idx - out_start;
	wire        in_readout  = rel_idx < {3'h0, out_len};
	wire        last_out    = in_readout && (rel_idx == {3'h0, out_len - 5'h01});
	wire        hold_busy   = (hold_cnt != '0);
	wire        ignore_byte = in_readout && out_is_reg;
	wire        limited     = power_down || !start_hi;
	wire        op_exit     = byte_in[7:1] == adc_cmd_pkg::CMD_EXIT_PD;
	wire        op_rd_once  = byte_in[7:1] == adc_cmd_pkg::CMD_READ_ONCE;
	wire        op_cont     = byte_in[7:1] == adc_cmd_pkg::CMD_CONT_READ;
	wire        op_stop     = byte_in[7:1] == adc_cmd_pkg::CMD_STOP_CONT;
	wire        low_ok      = op_exit || op_rd_once || op_cont || op_stop;
	wire        take        = rx_event && (state == adc_cmd_pkg::ST_IDLE) && !hold_busy
	                          && !ignore_byte && (!limited || low_ok);
	wire        is_exit     = take && op_exit;
	wire        is_sleep    = take && byte_in[7:1] == adc_cmd_pkg::CMD_ENTER_PD;
	wire        is_sync     = take && byte_in[7:1] == adc_cmd_pkg::CMD_RESTART;
	wire        is_reset    = take && byte_in[7:1] == adc_cmd_pkg::CMD_RESET;
	wire        is_rd_once  = take && op_rd_once;
	wire        is_cont     = take && op_cont;
	wire        is_stop     = take && op_stop;
	wire        is_register_read_cmd     = take && byte_in[7:4] == adc_cmd_pkg::CMD_REG_READ;
	wire        is_register_write_cmd     = take && byte_in[7:4] == adc_cmd_pkg::CMD_REG_WRITE;
	wire        is_ocal     = take && byte_in == adc_cmd_pkg::CMD_SYS_OFFSET;
	wire        is_gcal     = take && byte_in == adc_cmd_pkg::CMD_SYS_GAIN;
	wire        is_scal     = take && byte_in == adc_cmd_pkg::CMD_INT_OFFSET;
	wire        rd_load     = rx_event && !hold_busy && (state == adc_cmd_pkg::ST_RD_COUNT);
	wire        wr_strobe   = rx_event && !hold_busy && (state == adc_cmd_pkg::ST_WR_DATA);
	wire        auto_load   = conv_in.valid && cont_mode && !hold_busy;
	wire  [adc_cmd_pkg::OUT_BYTES-1:0][7:0] latest_bytes = {112'h0, latest[7:0], latest[15:8]};
	wire  [adc_cmd_pkg::OUT_BYTES-1:0][7:0] new_bytes =
		{112'h0, conv_in.code[7:0], conv_in.code[15:8]};

	// Register read payload, wrapping to zero past the last entry
	logic [adc_cmd_pkg::OUT_BYTES-1:0][7:0] rd_payload;
	always_comb begin
		logic [3:0] a;
		a = addr_q;
		rd_payload = '0;
		for (int i = 0; i < adc_cmd_pkg::OUT_BYTES; i++) begin
			rd_payload[i] = rd_reg(a);
			a = next_addr(a);
		end
	end

	// Multi-byte command sequencer; the all-ones byte falls through untouched
	always_ff @(posedge mclk) begin
		if (sys_rst || cs_high || hold_busy) begin
			state   <= adc_cmd_pkg::ST_IDLE;
			addr_q  <= 4'h0;
			wr_left <= 4'h0;
		end else begin
			case (state)
				adc_cmd_pkg::ST_IDLE: begin
					if (is_register_read_cmd || is_register_write_cmd) begin
						addr_q <= byte_in[3:0];
						state  <= is_register_read_cmd ? adc_cmd_pkg::ST_RD_COUNT : adc_cmd_pkg::ST_WR_COUNT;
					end
				end
				adc_cmd_pkg::ST_RD_COUNT: begin
					if (rx_event)
						state <= adc_cmd_pkg::ST_IDLE;
				end
				adc_cmd_pkg::ST_WR_COUNT: begin
					if (rx_event) begin
						wr_left <= byte_in[3:0];
						state   <= adc_cmd_pkg::ST_WR_DATA;
					end
				end
				adc_cmd_pkg::ST_WR_DATA: begin
					if (wr_strobe) begin
						addr_q  <= next_addr(addr_q);
						wr_left <= wr_left - 4'h1;
						if (wr_left == 4'h0)
							state <= adc_cmd_pkg::ST_IDLE;
					end
				end
				default: state <= adc_cmd_pkg::ST_IDLE;
			endcase
		end
	end

	// Output image: command loads win over the automatic load in the same cycle
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			out_buf    <= '0;
			out_start  <= 8'h00;
			out_len    <= 5'h00;
			out_is_reg <= 1'b0;
		end else if (rd_load) begin
			out_buf    <= rd_payload;
			out_start  <= rx_idx + 8'h01;
			out_len    <= {1'b0, byte_in[3:0]} + 5'h01;
			out_is_reg <= 1'b1;
		end else if (is_rd_once) begin
			out_buf    <= latest_bytes;
			out_start  <= rx_idx + 8'h01;
			out_len    <= adc_cmd_pkg::RESULT_BYTES;
			out_is_reg <= 1'b0;
		end else if (auto_load) begin
			out_buf    <= new_bytes;
			out_start  <= rx_idx;
			out_len    <= adc_cmd_pkg::RESULT_BYTES;
			out_is_reg <= 1'b0;
		end else if (cs_high) begin
			out_start <= 8'h00;
			if (out_is_reg)
				out_len <= 5'h00;
		end
	end

	// Configuration registers; reset hold keeps them at defaults
	always_ff @(posedge mclk) begin
		if (sys_rst || hold_busy) begin
			cfg_regs <= adc_cmd_pkg::REG_RESET;
		end else if (wr_strobe) begin
			if (addr_q < 4'(adc_cmd_pkg::REG_COUNT))
				cfg_regs[addr_q] <= byte_in & ~ro_mask(addr_q);
		end else if (cal_in.done) begin
			if (cal_req.kind == adc_cmd_pkg::CAL_SYS_GAIN) begin
				cfg_regs[adc_cmd_pkg::OFS_GAIN_LOW]  <= cal_in.value[7:0];
				cfg_regs[adc_cmd_pkg::OFS_GAIN_MID]  <= cal_in.value[15:8];
				cfg_regs[adc_cmd_pkg::OFS_GAIN_HIGH] <= cal_in.value[23:16];
			end else begin
				cfg_regs[adc_cmd_pkg::OFS_OFFSET_LOW]  <= cal_in.value[7:0];
				cfg_regs[adc_cmd_pkg::OFS_OFFSET_MID]  <= cal_in.value[15:8];
				cfg_regs[adc_cmd_pkg::OFS_OFFSET_HIGH] <= cal_in.value[23:16];
			end
		end
	end

	// Reset command hold; serial bytes arriving meanwhile are dropped
	always_ff @(posedge mclk) begin
		if (sys_rst)
			hold_cnt <= '0;
		else if (is_reset)
			hold_cnt <= HOLD_W'(RESET_HOLD);
		else if (hold_busy)
			hold_cnt <= hold_cnt - HOLD_W'(1);
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			filter_clear <= 1'b1;
			conv_restart <= 1'b0;
		end else begin
			filter_clear <= is_sync || is_reset || hold_busy;
			conv_restart <= is_sync || (hold_cnt == HOLD_W'(1));
		end
	end

	// Power-down waits for the running conversion to finish
	always_ff @(posedge mclk) begin
		if (sys_rst || hold_busy) begin
			power_down <= 1'b0;
			sleep_pend <= 1'b0;
		end else if (is_exit && start_hi) begin
			power_down <= 1'b0;
			sleep_pend <= 1'b0;
		end else if (is_sleep) begin
			sleep_pend <= 1'b1;
		end else if (sleep_pend && conv_in.valid) begin
			power_down <= 1'b1;
			sleep_pend <= 1'b0;
		end
	end

	// Reference follows its own field only, never the power-down state
	always_ff @(posedge mclk) begin
		if (sys_rst)
			ref_power_ctrl <= 2'h0;
		else
			ref_power_ctrl <= cfg_regs[adc_cmd_pkg::OFS_REF_CLK_CAL][adc_cmd_pkg::REF_CTRL_LSB +: 2];
	end

	// Mode change waits for the next ready event, which still loads under the old mode
	always_ff @(posedge mclk) begin
		if (sys_rst || hold_busy) begin
			cont_mode <= 1'b1;
			mode_pend <= 1'b0;
			mode_next <= 1'b1;
		end else if (is_cont || is_stop) begin
			mode_pend <= 1'b1;
			mode_next <= is_cont;
		end else if (conv_in.valid && mode_pend) begin
			cont_mode <= mode_next;
			mode_pend <= 1'b0;
		end
	end

	// Ready rises for one cycle before each fall so a new result always shows an edge
	always_ff @(posedge mclk) begin
		if (sys_rst || hold_busy) begin
			result_ready_n <= 1'b1;
			ready_fall     <= 1'b0;
			latest         <= 16'h0000;
		end else if (conv_in.valid) begin
			result_ready_n <= 1'b1;
			ready_fall     <= 1'b1;
			latest         <= conv_in.code;
		end else if (ready_fall) begin
			result_ready_n <= 1'b0;
			ready_fall     <= 1'b0;
		end else if (rx_event && last_out) begin
			result_ready_n <= 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cal_req <= '{start: 1'b0, kind: adc_cmd_pkg::CAL_SYS_OFFSET};
		end else begin
			cal_req.start <= is_ocal || is_gcal || is_scal;
			if (is_gcal)
				cal_req.kind <= adc_cmd_pkg::CAL_SYS_GAIN;
			else if (is_scal)
				cal_req.kind <= adc_cmd_pkg::CAL_INT_OFFSET;
			else if (is_ocal)
				cal_req.kind <= adc_cmd_pkg::CAL_SYS_OFFSET;
		end
	end

endmodule // adc_serial_command_decoder

/* testbench/adc_cmd_checker_sva.sv */
// Concurrent checks on the command decoder ports
`timescale 1ns/1ps
module adc_cmd_checker (
	input wire logic                              mclk,           // System clock
	input wire logic                              sys_rst,        // Sync reset, high
	input wire logic                              start_pin,      // Start pin
	input wire adc_cmd_pkg::conv_in_s             conv_in,        // Finished conversion
	input wire adc_cmd_pkg::cal_in_s              cal_in,         // Finished calibration
	input wire logic                              result_ready_n, // Result ready, low
	input wire logic                              power_down,     // Power-down state
	input wire logic                              filter_clear,   // Clear decimator
	input wire logic                              conv_restart,   // Start pulse
	input wire adc_cmd_pkg::cal_req_s             cal_req,        // Calibration request
	input wire logic [1:0]                        ref_power_ctrl, // Reference control
	input wire logic [adc_cmd_pkg::REG_COUNT-1:0][7:0] cfg_regs   // Register file
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	AST_RESET_DEFAULTS: assert property ($fell(sys_rst) |-> cfg_regs == adc_cmd_pkg::REG_RESET && result_ready_n && !power_down)
		else $error("register file not at defaults after reset");
	AST_READY_EVENT: assert property (conv_in.valid |=> result_ready_n ##1 !result_ready_n)
		else $error("ready event shape wrong after conversion");
	AST_OFFSET_UPDATE: assert property (cal_in.done && cal_req.kind != adc_cmd_pkg::CAL_SYS_GAIN |=> cfg_regs[6:4] == $past(cal_in.value))
		else $error("offset registers not updated");
	AST_GAIN_UPDATE: assert property (cal_in.done && cal_req.kind == adc_cmd_pkg::CAL_SYS_GAIN |=> cfg_regs[9:7] == $past(cal_in.value))
		else $error("gain registers not updated");
	AST_REF_FOLLOWS: assert property ($stable(cfg_regs[2]) ##1 $stable(cfg_regs[2]) |-> ref_power_ctrl == cfg_regs[2][6:5])
		else $error("reference control differs from its field");
	AST_PD_KEEPS_REF: assert property ($rose(power_down) |-> $stable(ref_power_ctrl))
		else $error("power-down entry touched reference control");
	AST_PD_AFTER_CONV: assert property ($rose(power_down) |-> $past(conv_in.valid) || $past(conv_in.valid, 2) || $past(conv_in.valid, 3) || $past(conv_in.valid, 4))
		else $error("power-down entered before conversion end");
	AST_START_LOW_HOLDS: assert property (power_down && !start_pin && !$past(start_pin) && !$past(start_pin, 2) && !$past(start_pin, 3) |=> power_down)
		else $error("left power-down with start pin low");
	AST_RESTART_CLEARS: assert property (conv_restart |-> filter_clear || $past(filter_clear))
		else $error("restart without filter clear");
	AST_RESTART_PULSE: assert property (conv_restart |=> !conv_restart)
		else $error("restart pulse longer than one cycle");
	AST_CAL_PULSE: assert property (cal_req.start |=> !cal_req.start)
		else $error("calibration request longer than one cycle");

	COV_READY: cover property (conv_in.valid ##2 !result_ready_n);
	COV_SLEEP: cover property ($rose(power_down));
	COV_CAL: cover property (cal_req.start);
endmodule // adc_cmd_checker

bind adc_serial_command_decoder adc_cmd_checker u_checker (
	.mclk(mclk), .sys_rst(sys_rst), .start_pin(start_pin), .conv_in(conv_in),
	.cal_in(cal_in), .result_ready_n(result_ready_n), .power_down(power_down),
	.filter_clear(filter_clear), .conv_restart(conv_restart), .cal_req(cal_req),
	.ref_power_ctrl(ref_power_ctrl), .cfg_regs(cfg_regs)
);

/* testbench/spi_host_model.sv */
// Host serial master model driving the command link
`timescale 1ns/1ps
module spi_host_model (
	output logic      serial_clk, // Link clock, still outside bytes
	output logic      cs_n,       // Chip select, low
	output logic      serial_in,  // Host to device data
	input  wire logic serial_out  // Device to host data
);
	// Chip select rises only once the link logic is listening, so its reset edge is never lost
	initial begin
		serial_clk = 1'b0;
		cs_n       = 1'b0;
		serial_in  = 1'b1;
		#1 cs_n = 1'b1;
	end
	task automatic select();
		cs_n = 1'b0;
		#100;
	endtask
	task automatic deselect();
		cs_n = 1'b1;
		#200;
	endtask
	// Whole bytes only, 12 ns per bit; the gap after covers decode and output loads
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			serial_in = tx[i];
			#6 serial_clk = 1'b1;
			#6 serial_clk = 1'b0;
			rx[i] = serial_out;
		end
		serial_in = ~tx[0];
		#300;
	endtask
endmodule // spi_host_model

/* testbench/tb_adc_serial_command_decoder.sv */
// Testbench for the converter serial command decoder
`timescale 1ns/1ps
module tb_adc_serial_command_decoder;
	logic                                     mclk, sys_rst, start_pin, clk_stat;
	logic                                     serial_clk, cs_n, serial_in, serial_out;
	logic                                     result_ready_n, power_down;
	logic                                     filter_clear, conv_restart;
	logic [1:0]                               ref_power_ctrl;
	adc_cmd_pkg::conv_in_s                    conv_in;
	adc_cmd_pkg::cal_in_s                     cal_in;
	adc_cmd_pkg::cal_req_s                    cal_req;
	logic [adc_cmd_pkg::REG_COUNT-1:0][7:0]   cfg_regs;
	logic [7:0]                               rx;
	int                                       num_errors, num_checks, n, restarts;

	adc_serial_command_decoder #(.RESET_HOLD(20)) DUT (
		.mclk(mclk), .sys_rst(sys_rst), .serial_clk(serial_clk), .cs_n(cs_n),
		.serial_in(serial_in), .serial_out(serial_out), .start_pin(start_pin),
		.clk_stat(clk_stat), .conv_in(conv_in), .cal_in(cal_in),
		.result_ready_n(result_ready_n), .power_down(power_down),
		.filter_clear(filter_clear), .conv_restart(conv_restart), .cal_req(cal_req),
		.ref_power_ctrl(ref_power_ctrl), .cfg_regs(cfg_regs)
	);
	spi_host_model host (
		.serial_clk(serial_clk), .cs_n(cs_n), .serial_in(serial_in), .serial_out(serial_out)
	);

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// Restart pulses last one cycle, too short for the byte-paced checks to catch directly
	always @(posedge mclk) begin
		if (conv_restart === 1'b1)
			restarts++;
	end

	task automatic chk_word(input logic [23:0] got, input logic [23:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: value %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: flag %b, expected %b", $time, got, exp);
		end
	endtask
	task automatic cmd(input logic [7:0] b);
		host.xfer(b, rx);
	endtask
	task automatic rd(input logic [7:0] e);
		host.xfer(8'hFF, rx);
		chk_word({16'h0000, rx}, {16'h0000, e});
	endtask
	task automatic conv(input logic [15:0] code);
		@(posedge mclk) conv_in <= '{1'b1, code};
		@(posedge mclk) conv_in <= '{1'b0, code};
		repeat (4) @(posedge mclk);
	endtask
	task automatic check_defaults();
		for (int i = 0; i < adc_cmd_pkg::REG_COUNT; i++) begin
			chk_word({16'h0000, cfg_regs[i]}, {16'h0000, adc_cmd_pkg::REG_RESET[i]});
		end
	endtask
	task automatic tally_and_finish();
		$display("Checks %0d, errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		#200000;
		num_errors++;
		tally_and_finish();
	end

	initial begin
		sys_rst = 1'b1;
		start_pin = 1'b1;
		clk_stat = 1'b1;
		conv_in = '0;
		cal_in = '0;
		repeat (6) @(posedge mclk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge mclk);
		check_defaults();
		host.select();
		conv(16'hA55A);
		chk_bit(result_ready_n, 1'b0);
		rd(8'hA5);
		rd(8'h5A);
		chk_bit(result_ready_n, 1'b1);
		cmd(8'h41);
		cmd(8'h01);
		cmd(8'h3C);
		cmd(8'hC3);
		chk_word({16'h0000, cfg_regs[1]}, 24'h00003C);
		chk_word({16'h0000, cfg_regs[2]}, 24'h000043);
		chk_word({22'h000000, ref_power_ctrl}, 24'h000002);
		cmd(8'h22);
		cmd(8'h00);
		rd(8'hC3);
		cmd(8'h2E);
		cmd(8'h01);
		host.xfer(8'h06, rx);
		chk_word({16'h0000, rx}, 24'h000000);
		rd(8'h01);
		chk_word({16'h0000, cfg_regs[1]}, 24'h00003C);
		cmd(8'h16);
		conv(16'h1111);
		rd(8'h11);
		rd(8'h11);
		cmd(8'h20);
		cmd(8'h00);
		conv(16'h2222);
		rd(8'h01);
		cmd(8'h12);
		rd(8'h22);
		conv(16'h3333);
		host.xfer(8'h12, rx);
		chk_word({16'h0000, rx}, 24'h000022);
		rd(8'h33);
		rd(8'h33);
		cmd(8'h14);
		conv(16'h4444);
		conv(16'h5555);
		rd(8'h55);
		rd(8'h55);
		cmd(8'h12);
		rd(8'h55);
		for (int k = 0; k < 3; k++) begin
			cmd(8'h60 + 8'(k));
			@(posedge mclk) cal_in <= '{1'b1, 24'h123456 + 24'(k)};
			@(posedge mclk) cal_in <= '{1'b0, 24'h000000};
			@(posedge mclk);
			chk_word((k == 1) ? cfg_regs[9:7] : cfg_regs[6:4], 24'h123456 + 24'(k));
		end
		cmd(8'h02);
		chk_bit(power_down, 1'b0);
		conv(16'h6666);
		chk_bit(power_down, 1'b1);
		cmd(8'h41);
		cmd(8'h02);
		cmd(8'h77);
		chk_word({16'h0000, cfg_regs[1]}, 24'h00003C);
		@(posedge mclk) start_pin <= 1'b0;
		repeat (4) @(posedge mclk);
		cmd(8'h00);
		chk_bit(power_down, 1'b1);
		@(posedge mclk) start_pin <= 1'b1;
		repeat (4) @(posedge mclk);
		cmd(8'h00);
		chk_bit(power_down, 1'b0);
		cmd(8'hFF);
		chk_word({16'h0000, cfg_regs[1]}, 24'h00003C);
		cmd(8'h04);
		chk_word(24'(restarts), 24'h000001);
		cmd(8'h06);
		chk_bit(filter_clear, 1'b1);
		n = 0;
		while (conv_restart !== 1'b1 && n < 100) begin
			@(posedge mclk);
			n++;
		end
		chk_bit(n >= 10 && n <= 20, 1'b1);
		repeat (4) @(posedge mclk);
		chk_word(24'(restarts), 24'h000002);
		check_defaults();
		host.deselect();
		tally_and_finish();
	end
endmodule // tb_adc_serial_command_decoder
